// [pwm_trig_pkg.sv]
// Constants, field layout and carrier types for the trigger and ch6 block.
// Assumes a 32-bit classic Wishbone slave and one 200 MHz clock.
// ****************************************************************
// How it works
// ****************************************************************
// How it works
// - Bit 2 routes event input 1 to port3 bit0 when clear, port6 bit2 set.
// - Bit 0 routes event input 0 to port0 bit0 when clear, port3 bit2 set.
// - Coupled ch4/ch5 use ch4 pin routing bits instead of ch5 bits.
// - Bits 5:4 give event 1 filter of 2, 4, 8, 16 oscillator clocks.
// - Bits 1:0 give event 0 filter with the same encoding.
// - Programmed lengths only on oscillator clock; otherwise two low-speed clocks.
// - Coupled ch4/ch5 use ch4 sampling fields instead of ch5 fields.
// - Prescale code divides selected clock by 1 to 64 in powers of two.
// - Prescale code 111 must not be used; it behaves as divide by one.
// - Coupled ch4/ch5 use ch4 prescale field instead of ch5 field.
// - Ch6 period is 16 bits in two bytes, resetting to all ones.
// - Writing a zero period loads one into the period buffer.
// - Ch6 duty is 16 bits in two bytes, resetting to zero.
// - Coupled ch6/ch7 with dead time: effective duty is ch6 plus ch7 duty.
// - Coupled ch6/ch7 with dead time: ch7 period comes from ch6 duty.
// - Triggers sampled by oscillator clock when selected, else low-speed clock.
// - Clock select 00 low-speed, 01 oscillator, 11 external, 10 unused.
package pwm_trig_pkg;

  // ****************************************************************
  // Register indices; byte address is four times the index
  // ****************************************************************
  localparam logic [15:0] IDX_CH5_ROUTE = 16'hF4BA;
  localparam logic [15:0] IDX_CH5_SAMPLE = 16'hF4BB;
  localparam logic [15:0] IDX_CH5_PRESCALE = 16'hF4BC;
  localparam logic [15:0] IDX_CH5_AUX = 16'hF4BE;
  localparam logic [15:0] IDX_STATUS = 16'hF4BF;
  localparam logic [15:0] IDX_CH6_PERIOD_LO = 16'hF4C0;
  localparam logic [15:0] IDX_CH6_PERIOD_HI = 16'hF4C1;
  localparam logic [15:0] IDX_CH6_DUTY_LO = 16'hF4C2;
  localparam logic [15:0] IDX_CH6_DUTY_HI = 16'hF4C3;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int POS_EV1_ROUTE = 2;
  localparam int POS_EV0_ROUTE = 0;
  localparam int POS_EV1_LEN = 4;
  localparam int POS_EV0_LEN = 0;
  localparam int POS_PRESCALE = 0;
  localparam int POS_CLK_SRC = 0;
  localparam int POS_CH45_COUPLED = 2;
  localparam int POS_CH67_COUPLED = 3;
  localparam int POS_DEAD_TIME = 4;

  // ****************************************************************
  // Reset values and fixed figures
  // ****************************************************************
  localparam logic [7:0] RST_CH5_CFG = 8'h00;
  localparam logic [7:0] RST_PERIOD_BYTE = 8'hFF;
  localparam logic [7:0] RST_DUTY_BYTE = 8'h00;
  localparam logic [15:0] PERIOD_MIN = 16'h0001;
  localparam logic [4:0] FIXED_SAMPLES = 5'h02;
  localparam logic [2:0] PRESCALE_BAD = 3'h7;

  typedef enum logic [1:0] {
    CLK_LOW_SPEED = 2'h0,
    CLK_OSC = 2'h1,
    CLK_UNUSED = 2'h2,
    CLK_EXTERNAL = 2'h3
  } clk_src_t;

  // Candidate pins for the two pair-4/5 event inputs
  typedef struct packed {
    logic port0_bit0;
    logic port3_bit2;
    logic port3_bit0;
    logic port6_bit2;
  } port_pins_t;

  // Settings owned by channel 4, applied here when coupled
  typedef struct packed {
    logic ch4_event1_pin_route;
    logic ch4_event0_pin_route;
    logic [1:0] ch4_event1_sample_len;
    logic [1:0] ch4_event0_sample_len;
    logic [2:0] ch4_prescale_select;
  } ch4_cfg_t;

  // Derived values handed to the counters
  typedef struct packed {
    logic [15:0] ch6_period_buffer;
    logic [15:0] ch6_effective_duty;
    logic ch7_period_override;
    logic [15:0] ch7_period_value;
  } ch6_out_t;

endpackage

// [pwm_trig_period.sv]
// Ch5 trigger routing, filtering and prescaling; ch6 period and duty.
// Assumes pins and timing clocks arrive synchronous to clock, as level
// signals sampled here; channel 4 and channel 7 supply their settings.
module pwm_trig_period
  import pwm_trig_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [17:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire port_pins_t pins,
  input wire logic low_speed_clock,
  input wire logic oscillator_clock,
  input wire logic external_clock,
  input wire ch4_cfg_t ch4_cfg,
  input wire logic [15:0] ch7_duty_value,
  output logic [1:0] pair45_events,
  output logic ch5_count_tick,
  output ch6_out_t ch6_out
);

  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic ack_r;
  logic [31:0] dat_r;
  wire req = cyc_i && stb_i;
  wire wr_now = req && we_i && ack_r && sel_i[0];
  wire [15:0] idx = adr_i[17:2];
  wire hit_route = idx == IDX_CH5_ROUTE;
  wire hit_sample = idx == IDX_CH5_SAMPLE;
  wire hit_pre = idx == IDX_CH5_PRESCALE;
  wire hit_aux = idx == IDX_CH5_AUX;
  wire hit_stat = idx == IDX_STATUS;
  wire hit_pl = idx == IDX_CH6_PERIOD_LO;
  wire hit_ph = idx == IDX_CH6_PERIOD_HI;
  wire hit_dl = idx == IDX_CH6_DUTY_LO;
  wire hit_dh = idx == IDX_CH6_DUTY_HI;

  // ****************************************************************
  // Software registers
  // ****************************************************************
  logic ev1_route_r;
  logic ev0_route_r;
  logic [1:0] ev1_len_r;
  logic [1:0] ev0_len_r;
  logic [2:0] pre_r;
  logic [1:0] clk_src_r;
  logic ch45_coupled_mode_r;
  logic ch67_coupled_mode_r;
  logic ch6_dead_time_enable_r;
  logic [15:0] period_r;
  logic [15:0] duty_r;
  logic [15:0] period_buf_r;

  // Only the documented bits are stored, so reserved bits cannot latch
  always_ff @(posedge clock) begin
    if (rst) begin
      ev1_route_r <= RST_CH5_CFG[POS_EV1_ROUTE];
      ev0_route_r <= RST_CH5_CFG[POS_EV0_ROUTE];
      ev1_len_r <= RST_CH5_CFG[POS_EV1_LEN +: 2];
      ev0_len_r <= RST_CH5_CFG[POS_EV0_LEN +: 2];
      pre_r <= RST_CH5_CFG[POS_PRESCALE +: 3];
      clk_src_r <= RST_CH5_CFG[POS_CLK_SRC +: 2];
      ch45_coupled_mode_r <= 1'b0;
      ch67_coupled_mode_r <= 1'b0;
      ch6_dead_time_enable_r <= 1'b0;
    end else if (wr_now) begin
      if (hit_route) begin
        ev1_route_r <= dat_i[POS_EV1_ROUTE];
        ev0_route_r <= dat_i[POS_EV0_ROUTE];
      end
      if (hit_sample) begin
        ev1_len_r <= dat_i[POS_EV1_LEN +: 2];
        ev0_len_r <= dat_i[POS_EV0_LEN +: 2];
      end
      if (hit_pre) begin
        pre_r <= dat_i[POS_PRESCALE +: 3];
      end
      if (hit_aux) begin
        clk_src_r <= dat_i[POS_CLK_SRC +: 2];
        ch45_coupled_mode_r <= dat_i[POS_CH45_COUPLED];
        ch67_coupled_mode_r <= dat_i[POS_CH67_COUPLED];
        ch6_dead_time_enable_r <= dat_i[POS_DEAD_TIME];
      end
    end
  end

  // Byte halves merge into one word; each period byte write reloads the buffer
  wire [15:0] period_nxt = hit_pl ? {period_r[15:8], dat_i[7:0]} :
                                    {dat_i[7:0], period_r[7:0]};
  wire [15:0] duty_nxt = hit_dl ? {duty_r[15:8], dat_i[7:0]} :
                                  {dat_i[7:0], duty_r[7:0]};
  wire per_wr = wr_now && (hit_pl || hit_ph);
  wire duty_wr = wr_now && (hit_dl || hit_dh);
  wire [15:0] buf_nxt = (period_nxt == 16'h0000) ? PERIOD_MIN : period_nxt;

  always_ff @(posedge clock) begin
    if (rst) begin
      period_r <= {RST_PERIOD_BYTE, RST_PERIOD_BYTE};
      period_buf_r <= {RST_PERIOD_BYTE, RST_PERIOD_BYTE};
      duty_r <= {RST_DUTY_BYTE, RST_DUTY_BYTE};
    end else begin
      if (per_wr) begin
        period_r <= period_nxt;
        period_buf_r <= buf_nxt;
      end
      if (duty_wr) begin
        duty_r <= duty_nxt;
      end
    end
  end

  // ****************************************************************
  // Effective settings under coupling
  // ****************************************************************
  wire eff_ev1_route = ch45_coupled_mode_r ? ch4_cfg.ch4_event1_pin_route
                                            : ev1_route_r;
  wire eff_ev0_route = ch45_coupled_mode_r ? ch4_cfg.ch4_event0_pin_route
                                            : ev0_route_r;
  wire [1:0] eff_ev1_len = ch45_coupled_mode_r ? ch4_cfg.ch4_event1_sample_len
                                                : ev1_len_r;
  wire [1:0] eff_ev0_len = ch45_coupled_mode_r ? ch4_cfg.ch4_event0_sample_len
                                                : ev0_len_r;
  wire [2:0] eff_pre = ch45_coupled_mode_r ? ch4_cfg.ch4_prescale_select
                                            : pre_r;
  wire [2:0] div_code = (eff_pre == PRESCALE_BAD) ? 3'h0 : eff_pre;

  // ****************************************************************
  // Clock edges and prescaler
  // ****************************************************************
  logic ls_q_r;
  logic osc_q_r;
  logic ext_q_r;
  logic [5:0] pre_cnt_r;
  always_ff @(posedge clock) begin
    if (rst) begin
      ls_q_r <= 1'b0;
      osc_q_r <= 1'b0;
      ext_q_r <= 1'b0;
    end else begin
      ls_q_r <= low_speed_clock;
      osc_q_r <= oscillator_clock;
      ext_q_r <= external_clock;
    end
  end
  wire ls_edge = low_speed_clock && !ls_q_r;
  wire osc_edge = oscillator_clock && !osc_q_r;
  wire ext_edge = external_clock && !ext_q_r;
  wire osc_mode = clk_src_t'(clk_src_r) == CLK_OSC;
  // Unused code 10 gives no edges: the channel simply stays frozen
  wire sel_edge = (clk_src_t'(clk_src_r) == CLK_LOW_SPEED) ? ls_edge :
                  osc_mode ? osc_edge :
                  (clk_src_t'(clk_src_r) == CLK_EXTERNAL) ? ext_edge : 1'b0;
  wire [5:0] div_mask = 6'((7'h01 << div_code) - 7'h01);
  wire tick_w = sel_edge && ((pre_cnt_r & div_mask) == div_mask);
  always_ff @(posedge clock) begin
    if (rst) begin
      pre_cnt_r <= 6'h00;
      ch5_count_tick <= 1'b0;
    end else begin
      if (sel_edge) begin
        pre_cnt_r <= 6'(pre_cnt_r + 6'h01);
      end
      ch5_count_tick <= tick_w;
    end
  end

  // ****************************************************************
  // Event pin routing and glitch filters
  // ****************************************************************
  wire sample_edge = osc_mode ? osc_edge : ls_edge;
  wire [1:0] ev_raw;
  assign ev_raw[1] = eff_ev1_route ? pins.port6_bit2 : pins.port3_bit0;
  assign ev_raw[0] = eff_ev0_route ? pins.port3_bit2 : pins.port0_bit0;
  wire [4:0] ev_len [2];
  assign ev_len[1] = osc_mode ? 5'(5'h02 << eff_ev1_len) : FIXED_SAMPLES;
  assign ev_len[0] = osc_mode ? 5'(5'h02 << eff_ev0_len) : FIXED_SAMPLES;
  logic [4:0] flt_cnt_r [2];

  for (genvar i = 0; i < 2; i++) begin : g_filter
    wire differs = ev_raw[i] != pair45_events[i];
    wire [4:0] cnt_inc = 5'(flt_cnt_r[i] + 5'h01);
    always_ff @(posedge clock) begin
      if (rst) begin
        flt_cnt_r[i] <= 5'h00;
        pair45_events[i] <= 1'b0;
      end else if (sample_edge) begin
        if (!differs) begin
          flt_cnt_r[i] <= 5'h00;
        end else if (cnt_inc >= ev_len[i]) begin
          pair45_events[i] <= ev_raw[i];
          flt_cnt_r[i] <= 5'h00;
        end else begin
          flt_cnt_r[i] <= cnt_inc;
        end
      end
    end
  end

  // ****************************************************************
  // Ch6 derived outputs
  // ****************************************************************
  wire dt_coupled = ch67_coupled_mode_r && ch6_dead_time_enable_r;
  // Sum wraps at 16 bits; software keeps duty below period to avoid it
  wire [15:0] duty_sum = 16'(duty_r + ch7_duty_value);
  always_ff @(posedge clock) begin
    if (rst) begin
      ch6_out <= '0;
    end else begin
      ch6_out.ch6_period_buffer <= period_buf_r;
      ch6_out.ch6_effective_duty <= dt_coupled ? duty_sum : duty_r;
      ch6_out.ch7_period_override <= dt_coupled;
      ch6_out.ch7_period_value <= duty_r;
    end
  end

  // ****************************************************************
  // Read data and acknowledge
  // ****************************************************************
  wire [7:0] rd_route = {5'h00, ev1_route_r, 1'b0, ev0_route_r};
  wire [7:0] rd_sample = {2'h0, ev1_len_r, 2'h0, ev0_len_r};
  wire [7:0] rd_pre = {5'h00, pre_r};
  wire [7:0] rd_aux = {3'h0, ch6_dead_time_enable_r, ch67_coupled_mode_r,
                       ch45_coupled_mode_r, clk_src_r};
  wire [7:0] rd_stat = {3'h0, div_code, pair45_events};
  wire [7:0] rd_byte = hit_route ? rd_route :
                       hit_sample ? rd_sample :
                       hit_pre ? rd_pre :
                       hit_aux ? rd_aux :
                       hit_stat ? rd_stat :
                       hit_pl ? period_r[7:0] :
                       hit_ph ? period_r[15:8] :
                       hit_dl ? duty_r[7:0] :
                       hit_dh ? duty_r[15:8] : 8'h00;

  // One wait state; unmapped addresses still answer, with zero
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req && !ack_r;
      if (req && !ack_r) begin
        dat_r <= {24'h00_0000, rd_byte};
      end
    end
  end
  assign ack_o = ack_r;
  assign dat_o = dat_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_zero_period_wr;
    per_wr && (period_nxt == 16'h0000);
  endsequence

  sequence s_dt_duty;
    dt_coupled ##1 1'b1;
  endsequence

  ack_single_a: assert property (@(posedge clock) disable iff (rst)
    req && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle after one wait");
  period_clamp_a: assert property (@(posedge clock) disable iff (rst)
    s_zero_period_wr |=> period_buf_r == 16'h0001 ##1 ch6_out.ch6_period_buffer == 16'h0001)
    else $error("zero period not clamped to one");
  period_keep_a: assert property (@(posedge clock) disable iff (rst)
    per_wr && period_nxt != 16'h0000 |=> period_buf_r == period_r)
    else $error("period buffer differs from period");
  duty_sum_a: assert property (@(posedge clock) disable iff (rst)
    s_dt_duty |-> ch6_out.ch6_effective_duty == 16'($past(duty_r) + $past(ch7_duty_value)))
    else $error("coupled duty is not the sum");
  ch7_period_a: assert property (@(posedge clock) disable iff (rst)
    s_dt_duty |-> ch6_out.ch7_period_override && ch6_out.ch7_period_value == $past(duty_r))
    else $error("ch7 period not from ch6 duty");
  div_one_a: assert property (@(posedge clock) disable iff (rst)
    sel_edge && (eff_pre == 3'h0 || eff_pre == 3'h7) |=> ch5_count_tick)
    else $error("divide by one missed an edge");
  div_gap_a: assert property (@(posedge clock) disable iff (rst)
    ch5_count_tick && eff_pre == 3'h1 && $stable(eff_pre) |-> !pre_cnt_r[0])
    else $error("divide by two ticked twice in a row");
  fixed_len_a: assert property (@(posedge clock) disable iff (rst)
    !osc_mode |-> ev_len[0] == 5'h02 && ev_len[1] == 5'h02)
    else $error("fixed sampling length not two");
  filter_hold_a: assert property (@(posedge clock) disable iff (rst)
    pair45_events[0] != $past(pair45_events[0]) |->
      $past(sample_edge) && $past(ev_raw[0]) == pair45_events[0] &&
      $past(flt_cnt_r[0]) + 5'h01 >= $past(ev_len[0]))
    else $error("event 0 changed before filter length");
  sample_src_a: assert property (@(posedge clock) disable iff (rst)
    osc_mode && !osc_edge |=> $stable(flt_cnt_r[1]) && $stable(pair45_events[1]))
    else $error("event 1 sampled off the oscillator edge");
  coupled_route_a: assert property (@(posedge clock) disable iff (rst)
    ch45_coupled_mode_r && ch4_cfg.ch4_event0_pin_route |-> ev_raw[0] == pins.port3_bit2)
    else $error("coupled routing ignored ch4 setting");
  coupled_pre_a: assert property (@(posedge clock) disable iff (rst)
    ch45_coupled_mode_r |-> div_code == ((ch4_cfg.ch4_prescale_select == 3'h7) ? 3'h0
                                          : ch4_cfg.ch4_prescale_select))
    else $error("coupled prescale ignored ch4 setting");
  reserved_zero_a: assert property (@(posedge clock) disable iff (rst)
    req && !ack_o && hit_sample |=> dat_o[7:6] == 2'h0 && dat_o[3:2] == 2'h0)
    else $error("reserved sampling bits read nonzero");

  // ****************************************************************
  // Checks on routing and filter lengths
  // ****************************************************************
  route0_a: assert property (
    !ch45_coupled_mode_r && !ev0_route_r |-> ev_raw[0] == pins.port0_bit0)
    else $error("event 0 not on its default pin");
  route0_alt_a: assert property (
    !ch45_coupled_mode_r && ev0_route_r |-> ev_raw[0] == pins.port3_bit2)
    else $error("event 0 not on its alternate pin");
  route1_a: assert property (
    !ch45_coupled_mode_r && ev1_route_r |-> ev_raw[1] == pins.port6_bit2)
    else $error("event 1 not on its alternate pin");
  coupled_route1_a: assert property (
    ch45_coupled_mode_r && ch4_cfg.ch4_event1_pin_route |-> ev_raw[1] == pins.port6_bit2)
    else $error("coupled event 1 routing ignored ch4");
  osc_len1_a: assert property (
    osc_mode && !ch45_coupled_mode_r && ev1_len_r == 2'h3 |-> ev_len[1] == 5'h10)
    else $error("event 1 length not sixteen");
  osc_len0_a: assert property (
    osc_mode && !ch45_coupled_mode_r && ev0_len_r == 2'h1 |-> ev_len[0] == 5'h04)
    else $error("event 0 length not four");
  coupled_len_a: assert property (
    osc_mode && ch45_coupled_mode_r && ch4_cfg.ch4_event1_sample_len == 2'h3 |->
      ev_len[1] == 5'h10)
    else $error("coupled event 1 length ignored ch4");
  sample_src0_a: assert property (
    !osc_mode && !ls_edge |=> $stable(flt_cnt_r[0]) && $stable(pair45_events[0]))
    else $error("event 0 sampled off the low-speed edge");
  filter_hold1_a: assert property (
    pair45_events[1] != $past(pair45_events[1]) |->
      $past(sample_edge) && $past(ev_raw[1]) == pair45_events[1] &&
      $past(flt_cnt_r[1]) + 5'h01 >= $past(ev_len[1]))
    else $error("event 1 changed before filter length");

  // ****************************************************************
  // Checks on bus, clock source and ch6
  // ****************************************************************
  sequence s_bus_idle;
    !cyc_i || !stb_i;
  endsequence

  ack_idle_a: assert property (
    s_bus_idle |=> !ack_o)
    else $error("acknowledge without a request");
  frozen_src_a: assert property (
    clk_src_t'(clk_src_r) == CLK_UNUSED |-> !sel_edge)
    else $error("unused clock source gave an edge");
  ext_src_a: assert property (
    clk_src_t'(clk_src_r) == CLK_EXTERNAL |-> sel_edge == ext_edge)
    else $error("external source not followed");
  period_high_a: assert property (
    per_wr && hit_ph |=> period_r[15:8] == $past(dat_i[7:0]))
    else $error("period high byte not stored");
  duty_low_a: assert property (
    duty_wr && hit_dl |=> duty_r[7:0] == $past(dat_i[7:0]))
    else $error("duty low byte not stored");
  duty_plain_a: assert property (
    !dt_coupled |=> ch6_out.ch6_effective_duty == $past(duty_r))
    else $error("uncoupled duty not the ch6 value");
  no_override_a: assert property (
    !dt_coupled |=> !ch6_out.ch7_period_override)
    else $error("ch7 period override while uncoupled");

endmodule

// [pwm_trig_partner.sv]
// Far-side model: the event pins and the three free-running timing clocks.
// Assumes the bench sets the pin levels it wants on pin_req.
module pwm_trig_partner
  import pwm_trig_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire port_pins_t pin_req,
  output port_pins_t pins,
  output logic low_speed_clock,
  output logic oscillator_clock,
  output logic external_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Timing clocks: low speed edge every 16 cycles, external 8, oscillator 4
  // ****************************************************************
  logic [3:0] div_r;
  assign pins = pin_req;
  assign low_speed_clock = div_r[3];
  assign oscillator_clock = div_r[1];
  assign external_clock = div_r[2];
  always_ff @(posedge clock) begin
    if (rst) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end
endmodule

// [pwm_trig_period_tb.sv]
// Self-checking bench for the trigger, prescale and ch6 block.
// Assumes the far-side model supplies pins and timing clocks.
module pwm_trig_period_tb
  import pwm_trig_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clock = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [17:0] adr = 18'h00000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h00000000, dat_o, seed = 32'h000002A5, r;
  logic ack_o, ls, osc, ext, tick;
  port_pins_t pin_req = 4'h0, pins;
  ch4_cfg_t ch4 = 9'h000;
  logic [15:0] ch7 = 16'h0000;
  logic [1:0] ev;
  ch6_out_t c6;
  logic [31:0] expq[$];
  int bad_count = 0, compares = 0, g, n;
  logic [15:0] ix[7] = '{IDX_CH5_ROUTE, IDX_CH5_SAMPLE, IDX_CH5_PRESCALE, IDX_CH6_PERIOD_LO,
    IDX_CH6_PERIOD_HI, IDX_CH6_DUTY_LO, IDX_CH6_DUTY_HI};
  logic [7:0] rv[7] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
  always #2.5 clock = ~clock;
  pwm_trig_period u_pwm_trig_period (.clock(clock), .rst(rst), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
    .pins(pins), .low_speed_clock(ls), .oscillator_clock(osc), .external_clock(ext),
    .ch4_cfg(ch4), .ch7_duty_value(ch7), .pair45_events(ev), .ch5_count_tick(tick),
    .ch6_out(c6));
  pwm_trig_partner u_pwm_trig_partner (.clock(clock), .rst(rst), .pin_req(pin_req),
    .pins(pins), .low_speed_clock(ls), .oscillator_clock(osc), .external_clock(ext));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Read when w is low: d is then the expected byte
  task automatic wb(input logic w, input logic [15:0] i, input logic [7:0] d);
    int k;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= {i, 2'b00};
    dat <= {24'h000000, w ? d : 8'h00};
    if (!w) expq.push_back({24'h000000, d});
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    if (k >= 50) check(32'h0, 32'h1, "no acknowledge");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_ev(input logic [1:0] v, input int lim);
    n = 0;
    while (ev !== v && n < lim) begin
      @(posedge clock);
      n++;
    end
  endtask
  task automatic wait_tick();
    n = 0;
    while (tick !== 1'b1 && n < 2100) begin
      @(posedge clock);
      n++;
    end
    @(posedge clock);
  endtask
  task automatic gap();
    repeat (2) wait_tick();
    g = 1;
    while (tick !== 1'b1 && g < 2100) begin
      @(posedge clock);
      g++;
    end
  endtask
  // ****************************************************************
  // Read monitor and watchdog
  // ****************************************************************
  always @(posedge clock) begin
    if (ack_o === 1'b1 && we === 1'b0 && cyc === 1'b1 && expq.size() > 0) begin
      check(dat_o, expq.pop_front(), "read data");
    end
  end
  initial begin
    repeat (60000) @(posedge clock);
    bad_count++;
    summarize();
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) wb(1'b0, ix[i], rv[i]);
    wb(1'b0, 16'h0100, 8'h00);
    check(c6.ch6_period_buffer, 16'hFFFF, "period buffer reset");
    wb(1'b1, IDX_CH5_ROUTE, 8'hFF);
    wb(1'b0, IDX_CH5_ROUTE, 8'h05);
    wb(1'b1, IDX_CH5_SAMPLE, 8'hFF);
    wb(1'b0, IDX_CH5_SAMPLE, 8'h33);
    wb(1'b1, IDX_CH5_PRESCALE, 8'hFF);
    wb(1'b0, IDX_CH5_PRESCALE, 8'h07);
    wb(1'b1, IDX_CH5_ROUTE, 8'h00);
    $display("test registers done");
    wb(1'b1, IDX_CH6_PERIOD_LO, 8'h34);
    wb(1'b1, IDX_CH6_PERIOD_HI, 8'h12);
    repeat (2) @(posedge clock);
    check(c6.ch6_period_buffer, 16'h1234, "period buffer");
    wb(1'b1, IDX_CH6_PERIOD_LO, 8'h00);
    wb(1'b1, IDX_CH6_PERIOD_HI, 8'h00);
    repeat (2) @(posedge clock);
    check(c6.ch6_period_buffer, PERIOD_MIN, "zero period clamp");
    wb(1'b0, IDX_CH6_PERIOD_HI, 8'h00);
    wb(1'b1, IDX_CH6_PERIOD_HI, 8'h02);
    r = xs();
    ch7 <= {8'h00, r[7:0]};
    wb(1'b1, IDX_CH6_DUTY_LO, 8'h00);
    wb(1'b1, IDX_CH6_DUTY_HI, 8'h01);
    wb(1'b0, IDX_CH6_DUTY_HI, 8'h01);
    wb(1'b1, IDX_CH5_AUX, 8'h18);
    repeat (2) @(posedge clock);
    check(c6.ch6_effective_duty, 16'h0100 + {8'h00, r[7:0]}, "duty sum");
    check(c6.ch7_period_override, 1'b1, "ch7 override");
    check(c6.ch7_period_value, 16'h0100, "ch7 period");
    $display("test period and duty done");
    // Glitch one sample edge short of the length, then a held level
    wb(1'b1, IDX_CH5_AUX, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, IDX_CH5_SAMPLE, {2'b00, k[1:0], 2'b00, k[1:0]});
      pin_req <= 4'hA;
      repeat (4 * ((2 << k) - 1) - 3) @(posedge clock);
      pin_req <= 4'h0;
      repeat (4 * (2 << k) + 8) @(posedge clock);
      check(ev, 2'h0, "glitch passed");
      pin_req <= 4'hA;
      wait_ev(2'h3, 4 * (2 << k) + 12);
      check(ev, 2'h3, "held level lost");
      pin_req <= 4'h0;
      wait_ev(2'h0, 4 * (2 << k) + 12);
    end
    wb(1'b1, IDX_CH5_AUX, 8'h00);
    pin_req <= 4'hA;
    wait_ev(2'h3, 56);
    check(ev, 2'h3, "fixed length");
    pin_req <= 4'h0;
    wait_ev(2'h0, 56);
    wb(1'b1, IDX_CH5_ROUTE, 8'h05);
    pin_req <= 4'h5;
    wait_ev(2'h3, 56);
    check(ev, 2'h3, "alternate pins");
    pin_req <= 4'hA;
    repeat (56) @(posedge clock);
    check(ev, 2'h0, "unrouted pins");
    wb(1'b1, IDX_CH5_ROUTE, 8'h00);
    ch4.ch4_event1_pin_route <= 1'b1;
    ch4.ch4_event0_pin_route <= 1'b1;
    ch4.ch4_event1_sample_len <= 2'h3;
    ch4.ch4_event0_sample_len <= 2'h3;
    wb(1'b1, IDX_CH5_AUX, 8'h04);
    pin_req <= 4'h5;
    wait_ev(2'h3, 56);
    check(ev, 2'h3, "coupled routing");
    pin_req <= 4'h0;
    wait_ev(2'h0, 56);
    wb(1'b1, IDX_CH5_SAMPLE, 8'h00);
    wb(1'b1, IDX_CH5_AUX, 8'h05);
    pin_req <= 4'h5;
    repeat (57) @(posedge clock);
    pin_req <= 4'h0;
    repeat (72) @(posedge clock);
    check(ev, 2'h0, "coupled length");
    $display("test event filter done");
    wb(1'b1, IDX_CH5_AUX, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, IDX_CH5_PRESCALE, c[7:0]);
      gap();
      check(g, (c == 7) ? 16 : (16 << c), "tick spacing");
    end
    r = xs() % 7;
    ch4.ch4_prescale_select <= r[2:0];
    wb(1'b1, IDX_CH5_PRESCALE, 8'h06);
    wb(1'b1, IDX_CH5_AUX, 8'h04);
    gap();
    check(g, 16 << r[2:0], "coupled prescale");
    wb(1'b1, IDX_CH5_PRESCALE, 8'h00);
    wb(1'b1, IDX_CH5_AUX, 8'h03);
    gap();
    check(g, 8, "external clock");
    wb(1'b1, IDX_CH5_AUX, 8'h02);
    repeat (2) @(posedge clock);
    wait_tick();
    check(n, 2100, "unused source ticked");
    $display("test prescaler done");
    summarize();
  end
endmodule
